// ==== verilog/spm_pkg.sv ====
`default_nettype none
package spm_pkg;
    // Pin function selects (per pin, 3-bit code)
    localparam logic [2:0] SPM_FN_GPIO = 3'h0;
    localparam logic [2:0] SPM_FN_ALT1 = 3'h1;
    localparam logic [2:0] SPM_FN_ALT2 = 3'h2;
    localparam logic [2:0] SPM_FN_ALT3 = 3'h3;
    localparam logic [2:0] SPM_FN_ALT4 = 3'h4;
    localparam int SPM_FN_W = 3;
    // Port C pin numbers used by alternate functions
    localparam int SPM_PC_BUFFERED_CLOCK_OUT  = 2;
    localparam int SPM_PC_TA0   = 3;
    localparam int SPM_PC_TA1   = 4;
    localparam int SPM_PC_XB7   = 5;
    localparam int SPM_PC_XB3   = 6;
    localparam int SPM_PC_SS    = 7;
    localparam int SPM_PC_MISO  = 8;
    localparam int SPM_PC_SCLK  = 9;
    // Internal reset stretch after the pin releases
    localparam int SPM_RST_CYCLES = 32;
    localparam int SPM_RST_W      = 6;
endpackage : spm_pkg
`default_nettype wire

// ==== verilog/spm_pin_mux.sv ====
// Contract
// (R1) Test-select pin sampled on test clock edges to step the TAP.
// (R2) After any reset, shared test pin selects test-select function.
// (R3) Low on external reset pin resets device and holds it.
// (R4) Internal reset releases synchronously after fixed clock count.
// (R5) Reset pin may become port D bit 4; external reset then disabled.
// (R6) After reset, reset pin defaults to reset function.
// (R7) During reset every muxed pin is input with pull-up.
// (R8) Port A, B, C pins individually in/out, default GPIO.
// (R9) Analog input reaches converter channel and comparator together.
// (R10) Port B bits 2,3 choose converter channel or reference.
// (R11) Port C bit 2 drives buffered clock chosen by select field.
// (R12) Slave-select on port C bit 7 marks transfer to receive.
// (R13) MISO is input in master mode, output in slave mode.
// (R14) Slave MISO floats when slave not selected.
// (R15) SPI clock outputs as master, input as slave.
// (R16) Serial 0 transmit on C2 or C7 is single-wire line.
// (R17) C2, C6, C9, C5 feed crossbar inputs 2, 3, 4, 7.
// (R18) C3, C4 carry timer A ch0/ch1 and comparator A/B outputs.
// (R19) One selected function drives each pin; inputs may observe.
`timescale 1ns/10ps
`default_nettype none
module spm_pin_mux
    import spm_pkg::*;
#(
    parameter int NA = 2,
    parameter int NB = 4,
    parameter int NC = 10,
    parameter int RST_CYCLES = SPM_RST_CYCLES
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_in,
    // Shared test-select / port D3 pin
    input  wire logic                  pd3_pin_in,
    output logic                       pd3_pin_out,
    output logic                       pd3_pin_oe_n_out,
    output logic                       pd3_pullup_out,
    input  wire logic                  pd3_gpio_sel_in,
    input  wire logic                  pd3_gpio_dout_in,
    input  wire logic                  pd3_gpio_dir_in,
    output logic                       port_d_bit3_io_out,
    output logic                       test_mode_sel_out,
    // Shared reset / port D4 pin (open drain)
    input  wire logic                  pd4_pin_in,
    output logic                       pd4_pin_out,
    output logic                       pd4_pin_oe_n_out,
    output logic                       pd4_pullup_out,
    input  wire logic                  pd4_gpio_sel_in,
    input  wire logic                  pd4_gpio_dout_in,
    input  wire logic                  pd4_gpio_dir_in,
    output logic                       port_d_bit4_io_out,
    input  wire logic                  other_reset_in,
    output logic                       int_rst_out,
    // Port A and B analog-capable pins
    input  wire logic [NA-1:0]         pa_pin_in,
    output logic      [NA-1:0]         pa_pin_out,
    output logic      [NA-1:0]         pa_pin_oe_n_out,
    output logic      [NA-1:0]         pa_pullup_out,
    input  wire logic [NA-1:0]         pa_analog_sel_in,
    input  wire logic [NA-1:0]         pa_gpio_dout_in,
    input  wire logic [NA-1:0]         pa_gpio_dir_in,
    output logic      [NA-1:0]         pa_gpio_din_out,
    output logic      [NA-1:0]         conv_a_chan_en_out,
    output logic      [NA-1:0]         comp_a_in_en_out,
    input  wire logic [NB-1:0]         pb_pin_in,
    output logic      [NB-1:0]         pb_pin_out,
    output logic      [NB-1:0]         pb_pin_oe_n_out,
    output logic      [NB-1:0]         pb_pullup_out,
    input  wire logic [NB-1:0]         pb_analog_sel_in,
    input  wire logic [NB-1:0]         pb_gpio_dout_in,
    input  wire logic [NB-1:0]         pb_gpio_dir_in,
    output logic      [NB-1:0]         pb_gpio_din_out,
    input  wire logic [1:0]            conv_b_ref_mode_in,
    output logic      [NB-1:0]         conv_b_chan_en_out,
    output logic      [NB-1:0]         comp_b_in_en_out,
    output logic                       conv_b_high_reference_out,
    output logic                       conv_b_low_reference_out,
    // Port C
    input  wire logic [NC-1:0]         pc_pin_in,
    output logic      [NC-1:0]         pc_pin_out,
    output logic      [NC-1:0]         pc_pin_oe_n_out,
    output logic      [NC-1:0]         pc_pullup_out,
    input  wire logic [NC*SPM_FN_W-1:0] pc_fn_sel_in,
    input  wire logic [NC-1:0]         pc_gpio_dout_in,
    input  wire logic [NC-1:0]         pc_gpio_dir_in,
    output logic      [NC-1:0]         pc_gpio_din_out,
    // Peripheral side
    input  wire logic [3:0]            clock_sources_in,
    input  wire logic [1:0]            clock_out_source_select_in,
    input  wire logic                  serial0_transmit_in,
    input  wire logic                  serial0_single_wire_in,
    output logic                       serial0_receive_out,
    input  wire logic [1:0]            timer_a_dout_in,
    input  wire logic [1:0]            timer_a_oe_in,
    output logic      [1:0]            timer_a_din_out,
    input  wire logic                  comp_a_output_in,
    input  wire logic                  comp_b_output_in,
    output logic      [3:0]            crossbar_in_out,
    input  wire logic                  spi_master_in,
    input  wire logic                  spi_sclk_in,
    input  wire logic                  spi_miso_in,
    output logic                       spi_sclk_out,
    output logic                       spi_miso_out,
    output logic                       spi_slave_sel_n_out,
    input  wire logic                  spi_ss_drive_in
);
    // Two-flop synchronisers for every pin level read by logic except the test-select pass-through
    localparam int NP = NA + NB + NC + 2;
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] next_sync1;
    always_comb begin
        next_sync1 = {pd4_pin_in, pd3_pin_in, pc_pin_in, pb_pin_in, pa_pin_in};
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
        end
    end
    logic [NA-1:0] pa_s;
    logic [NB-1:0] pb_s;
    logic [NC-1:0] pc_s;
    logic          pd3_s;
    logic          pd4_s;
    assign pa_s  = sync2[NA-1:0];
    assign pb_s  = sync2[NA+NB-1:NA];
    assign pc_s  = sync2[NA+NB+NC-1:NA+NB];
    assign pd3_s = sync2[NP-2];
    assign pd4_s = sync2[NP-1];

    // Reset stretcher: pin request or other sources restart the count
    logic [SPM_RST_W-1:0] rst_cnt;
    logic [SPM_RST_W-1:0] next_rst_cnt;
    logic                 pin_mode_io;
    logic                 next_pin_mode_io;
    logic                 ext_req;
    assign ext_req = !pin_mode_io && !pd4_s; // R3 R5
    always_comb begin
        next_rst_cnt = rst_cnt;
        if (ext_req || other_reset_in) begin
            next_rst_cnt = SPM_RST_W'(RST_CYCLES); // R4
        end else if (rst_cnt != '0) begin
            next_rst_cnt = rst_cnt - 1'b1; // R4
        end
    end
    // Pin role is taken only while running so reset always restores it
    always_comb begin
        next_pin_mode_io = (rst_cnt == '0) ? pd4_gpio_sel_in : 1'b0; // R6
    end
    logic                 pd3_mode_io;
    logic                 next_pd3_mode_io;
    always_comb begin
        next_pd3_mode_io = (rst_cnt == '0) ? pd3_gpio_sel_in : 1'b0; // R2
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rst_cnt     <= SPM_RST_W'(RST_CYCLES);
            pin_mode_io <= 1'b0; // R6
            pd3_mode_io <= 1'b0; // R2
        end else begin
            rst_cnt     <= next_rst_cnt;
            pin_mode_io <= next_pin_mode_io;
            pd3_mode_io <= next_pd3_mode_io;
        end
    end
    logic in_rst;
    assign in_rst      = rst_cnt != '0;
    assign int_rst_out = in_rst; // R3 R4

    // Role flops lag the count by one edge, so gate them with reset here
    logic pd3_role_io;
    assign pd3_role_io = pd3_mode_io && !in_rst; // R2
    // Test-select pass-through: the TAP samples on its own clock
    assign test_mode_sel_out  = pd3_role_io ? 1'b1 : pd3_pin_in; // R1
    assign port_d_bit3_io_out = pd3_s;
    assign port_d_bit4_io_out = pd4_s;

    // Port C function decode
    logic [SPM_FN_W-1:0] fsel [NC];
    logic                clk_buf;
    logic                ss_sel;
    logic                tx_drv;
    always_comb begin
        clk_buf = clock_sources_in[clock_out_source_select_in]; // R11
    end
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_fsel
            assign fsel[gi] = in_rst ? SPM_FN_GPIO
                            : pc_fn_sel_in[gi*SPM_FN_W +: SPM_FN_W]; // R8
        end
    endgenerate
    assign ss_sel = fsel[SPM_PC_SS] == SPM_FN_ALT1;
    assign spi_slave_sel_n_out = ss_sel ? pc_s[SPM_PC_SS] : 1'b1; // R12
    // Single wire: receive comes from the transmit pin
    logic tx_on_c2;
    logic tx_on_c7;
    assign tx_on_c2 = fsel[SPM_PC_BUFFERED_CLOCK_OUT] == SPM_FN_ALT1;
    assign tx_on_c7 = fsel[SPM_PC_SS] == SPM_FN_ALT2;
    assign tx_drv   = serial0_transmit_in;
    always_comb begin
        serial0_receive_out = 1'b1;
        if (serial0_single_wire_in && tx_on_c2) begin
            serial0_receive_out = pc_s[SPM_PC_BUFFERED_CLOCK_OUT]; // R16
        end else if (serial0_single_wire_in && tx_on_c7) begin
            serial0_receive_out = pc_s[SPM_PC_SS]; // R16
        end else if (fsel[SPM_PC_TA0] == SPM_FN_ALT3) begin
            serial0_receive_out = pc_s[SPM_PC_TA0];
        end else if (fsel[SPM_PC_MISO] == SPM_FN_ALT2) begin
            serial0_receive_out = pc_s[SPM_PC_MISO];
        end
    end
    assign crossbar_in_out = {
        fsel[SPM_PC_XB7] == SPM_FN_ALT2 ? pc_s[SPM_PC_XB7] : 1'b0,
        fsel[SPM_PC_SCLK] == SPM_FN_ALT2 ? pc_s[SPM_PC_SCLK] : 1'b0,
        fsel[SPM_PC_XB3] == SPM_FN_ALT2 ? pc_s[SPM_PC_XB3] : 1'b0,
        fsel[SPM_PC_BUFFERED_CLOCK_OUT] == SPM_FN_ALT3 ? pc_s[SPM_PC_BUFFERED_CLOCK_OUT] : 1'b0
    }; // R17
    assign timer_a_din_out = {pc_s[SPM_PC_TA1], pc_s[SPM_PC_TA0]}; // R18
    assign spi_sclk_out = pc_s[SPM_PC_SCLK]; // R15
    assign spi_miso_out = pc_s[SPM_PC_MISO]; // R13

    // Per-pin driver: at most one function owns output and enable
    always_comb begin
        pc_pin_out      = '0;
        pc_pin_oe_n_out = '1;
        for (int i = 0; i < NC; i++) begin
            if (fsel[i] == SPM_FN_GPIO && !in_rst) begin // R7
                pc_pin_out[i]      = pc_gpio_dout_in[i]; // R8 R19
                pc_pin_oe_n_out[i] = !pc_gpio_dir_in[i];
            end
        end
        unique case (fsel[SPM_PC_BUFFERED_CLOCK_OUT])
            SPM_FN_ALT1: begin
                pc_pin_out[SPM_PC_BUFFERED_CLOCK_OUT]      = tx_drv; // R16
                pc_pin_oe_n_out[SPM_PC_BUFFERED_CLOCK_OUT] = 1'b0;
            end
            SPM_FN_ALT4: begin
                pc_pin_out[SPM_PC_BUFFERED_CLOCK_OUT]      = clk_buf; // R11
                pc_pin_oe_n_out[SPM_PC_BUFFERED_CLOCK_OUT] = 1'b0;
            end
            default: ;
        endcase
        if (fsel[SPM_PC_TA0] == SPM_FN_ALT1) begin
            pc_pin_out[SPM_PC_TA0]      = timer_a_dout_in[0]; // R18
            pc_pin_oe_n_out[SPM_PC_TA0] = !timer_a_oe_in[0];
        end else if (fsel[SPM_PC_TA0] == SPM_FN_ALT2) begin
            pc_pin_out[SPM_PC_TA0]      = comp_a_output_in; // R18
            pc_pin_oe_n_out[SPM_PC_TA0] = 1'b0;
        end
        if (fsel[SPM_PC_TA1] == SPM_FN_ALT1) begin
            pc_pin_out[SPM_PC_TA1]      = timer_a_dout_in[1]; // R18
            pc_pin_oe_n_out[SPM_PC_TA1] = !timer_a_oe_in[1];
        end else if (fsel[SPM_PC_TA1] == SPM_FN_ALT2) begin
            pc_pin_out[SPM_PC_TA1]      = comp_b_output_in; // R18
            pc_pin_oe_n_out[SPM_PC_TA1] = 1'b0;
        end
        if (fsel[SPM_PC_SS] == SPM_FN_ALT1) begin
            pc_pin_out[SPM_PC_SS]      = 1'b0;
            pc_pin_oe_n_out[SPM_PC_SS] = !(spi_master_in && spi_ss_drive_in);
        end else if (tx_on_c7) begin
            pc_pin_out[SPM_PC_SS]      = tx_drv; // R16
            pc_pin_oe_n_out[SPM_PC_SS] = 1'b0;
        end
        if (fsel[SPM_PC_MISO] == SPM_FN_ALT1) begin
            pc_pin_out[SPM_PC_MISO]      = spi_miso_in; // R13
            pc_pin_oe_n_out[SPM_PC_MISO] = spi_master_in
                                         || spi_slave_sel_n_out; // R14
        end
        if (fsel[SPM_PC_SCLK] == SPM_FN_ALT1) begin
            pc_pin_out[SPM_PC_SCLK]      = spi_sclk_in; // R15
            pc_pin_oe_n_out[SPM_PC_SCLK] = !spi_master_in;
        end
    end
    assign pc_gpio_din_out = pc_s;
    assign pc_pullup_out   = pc_pin_oe_n_out; // R7

    // Analog pins: an analog pin never drives digitally
    assign pa_pin_out         = pa_gpio_dout_in;
    assign pa_pin_oe_n_out    = in_rst ? '1 : ~(pa_gpio_dir_in & ~pa_analog_sel_in); // R7 R19
    assign pa_pullup_out      = in_rst ? '1 : ~(pa_analog_sel_in | pa_gpio_dir_in); // R7
    assign pa_gpio_din_out    = pa_s;
    assign conv_a_chan_en_out = in_rst ? '0 : pa_analog_sel_in; // R9
    assign comp_a_in_en_out   = in_rst ? '0 : pa_analog_sel_in; // R9
    logic [NB-1:0] pb_an;
    assign pb_an           = in_rst ? '0 : pb_analog_sel_in;
    assign pb_pin_out      = pb_gpio_dout_in;
    assign pb_pin_oe_n_out = in_rst ? '1 : ~(pb_gpio_dir_in & ~pb_analog_sel_in); // R7 R19
    assign pb_pullup_out   = in_rst ? '1 : ~(pb_analog_sel_in | pb_gpio_dir_in); // R7
    assign pb_gpio_din_out = pb_s;
    assign comp_b_in_en_out = pb_an; // R9
    always_comb begin
        conv_b_chan_en_out = pb_an; // R9
        conv_b_chan_en_out[2] = pb_an[2] && !conv_b_ref_mode_in[0]; // R10
        conv_b_chan_en_out[3] = pb_an[3] && !conv_b_ref_mode_in[1]; // R10
    end
    assign conv_b_high_reference_out = pb_an[2] && conv_b_ref_mode_in[0]; // R10
    assign conv_b_low_reference_out  = pb_an[3] && conv_b_ref_mode_in[1]; // R10

    // Port D pins
    assign pd3_pin_out      = pd3_gpio_dout_in;
    assign pd3_pin_oe_n_out = !(pd3_role_io && pd3_gpio_dir_in); // R2
    assign pd3_pullup_out   = !(pd3_role_io && pd3_gpio_dir_in); // R7
    // Open drain: only ever drives low
    assign pd4_pin_out      = 1'b0;
    assign pd4_pin_oe_n_out = !(pin_mode_io && pd4_gpio_dir_in
                                && !pd4_gpio_dout_in && !in_rst); // R5
    assign pd4_pullup_out   = !pin_mode_io || !pd4_gpio_dir_in || in_rst; // R7

    a_reset_stretch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ext_req |=> rst_cnt == SPM_RST_W'(RST_CYCLES))
        else $error("reset not held"); // R4
    a_pin_default: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        in_rst |=> !pin_mode_io && !pd3_mode_io) else $error("pin role"); // R6
    a_reset_inputs: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        in_rst |-> pc_pin_oe_n_out == '1 && pc_pullup_out == '1)
        else $error("pin not input in reset"); // R7
    a_miso_float: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fsel[SPM_PC_MISO] == SPM_FN_ALT1 && !spi_master_in
        && spi_slave_sel_n_out |-> pc_pin_oe_n_out[SPM_PC_MISO])
        else $error("miso driven unselected"); // R14
    a_sclk_dir: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fsel[SPM_PC_SCLK] == SPM_FN_ALT1 |->
        pc_pin_oe_n_out[SPM_PC_SCLK] == !spi_master_in)
        else $error("sclk direction"); // R15
    a_ref_excl: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(conv_b_high_reference_out && conv_b_chan_en_out[2]))
        else $error("ref and channel both"); // R10
    a_analog_both: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        conv_a_chan_en_out == comp_a_in_en_out)
        else $error("analog split"); // R9
    a_od_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !pd4_pin_oe_n_out |-> !pd4_pin_out && pin_mode_io)
        else $error("open drain drove"); // R5
endmodule : spm_pin_mux
`default_nettype wire

// ==== dv/spm_periph_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module spm_periph_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    output logic      [3:0] clk_src_out,
    output logic            tx_out,
    output logic      [1:0] tmr_out,
    output logic            cmpa_out,
    output logic            cmpb_out,
    output logic            sclk_out,
    output logic            miso_out
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    // Every source is taken from one free-running counter, so each toggles and a stuck mux leg cannot hide
    always_comb begin
        next_cnt = cnt + 8'h01;
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
    assign clk_src_out = cnt[3:0];
    assign tx_out      = cnt[0] ^ cnt[2];
    assign tmr_out     = cnt[1:0];
    assign cmpa_out    = cnt[1];
    assign cmpb_out    = ~cnt[1];
    assign sclk_out    = cnt[0];
    assign miso_out    = cnt[2];
endmodule : spm_periph_model
`default_nettype wire

// ==== dv/spm_pin_mux_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module spm_pin_mux_tb;
    import spm_pkg::*;
    localparam int RC = 4;
    logic clk_sys_in, rst_in, other_reset_in, pd3_ext, pd4_ext;
    logic pd3_gpio_sel_in, pd3_gpio_dout_in, pd3_gpio_dir_in;
    logic pd4_gpio_sel_in, pd4_gpio_dout_in, pd4_gpio_dir_in;
    logic pd3_pin_out, pd3_pin_oe_n_out, pd3_pullup_out, port_d_bit3_io_out;
    logic test_mode_sel_out, pd4_pin_out, pd4_pin_oe_n_out, pd4_pullup_out;
    logic port_d_bit4_io_out, int_rst_out, conv_b_high_reference_out;
    logic conv_b_low_reference_out, serial0_single_wire_in;
    logic serial0_receive_out, serial0_transmit_in, comp_a_output_in;
    logic comp_b_output_in, spi_master_in, spi_sclk_in, spi_miso_in;
    logic spi_sclk_out, spi_miso_out, spi_slave_sel_n_out, spi_ss_drive_in;
    logic [1:0] pa_ext, pa_analog_sel_in, pa_gpio_dout_in, pa_gpio_dir_in;
    logic [1:0] pa_pin_out, pa_pin_oe_n_out, pa_pullup_out, pa_gpio_din_out;
    logic [1:0] conv_a_chan_en_out, comp_a_in_en_out, conv_b_ref_mode_in;
    logic [1:0] clock_out_source_select_in, timer_a_dout_in, timer_a_oe_in;
    logic [1:0] timer_a_din_out;
    logic [3:0] pb_ext, pb_analog_sel_in, pb_gpio_dout_in, pb_gpio_dir_in;
    logic [3:0] pb_pin_out, pb_pin_oe_n_out, pb_pullup_out, pb_gpio_din_out;
    logic [3:0] conv_b_chan_en_out, comp_b_in_en_out, clock_sources_in;
    logic [3:0] crossbar_in_out;
    logic [9:0] pc_ext, pc_gpio_dout_in, pc_gpio_dir_in, pc_pin_out;
    logic [9:0] pc_pin_oe_n_out, pc_pullup_out, pc_gpio_din_out;
    logic [29:0] pc_fn_sel_in;
    wire logic pd3_pin_in;
    wire logic pd4_pin_in;
    wire logic [1:0] pa_pin_in;
    wire logic [3:0] pb_pin_in;
    wire logic [9:0] pc_pin_in;
    int num_errors, cmp_count, tmo;
    // Pin level: design drives where enabled, the outside world elsewhere
    assign pd3_pin_in = pd3_pin_oe_n_out ? pd3_ext : pd3_pin_out;
    assign pd4_pin_in = pd4_pin_oe_n_out & pd4_ext;
    assign pa_pin_in = (pa_pin_oe_n_out & pa_ext) | (~pa_pin_oe_n_out & pa_pin_out);
    assign pb_pin_in = (pb_pin_oe_n_out & pb_ext) | (~pb_pin_oe_n_out & pb_pin_out);
    assign pc_pin_in = (pc_pin_oe_n_out & pc_ext) | (~pc_pin_oe_n_out & pc_pin_out);
    spm_pin_mux #(.RST_CYCLES(RC)) u_dut (.*);
    spm_periph_model u_peri (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .clk_src_out(clock_sources_in), .tx_out(serial0_transmit_in),
        .tmr_out(timer_a_dout_in), .cmpa_out(comp_a_output_in),
        .cmpb_out(comp_b_output_in), .sclk_out(spi_sclk_in),
        .miso_out(spi_miso_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : cyc
    task automatic fn(input int p, input logic [2:0] c);
        pc_fn_sel_in[p*3 +: 3] = c;
    endtask : fn
    task automatic chk_safe;
        chk({pd3_pin_oe_n_out, pd4_pin_oe_n_out, pa_pin_oe_n_out,
             pb_pin_oe_n_out, pc_pin_oe_n_out}, 32'h0003_FFFF);
        chk({pd3_pullup_out, pd4_pullup_out, pa_pullup_out, pb_pullup_out,
             pc_pullup_out}, 32'h0003_FFFF);
        chk({int_rst_out, test_mode_sel_out}, {1'b1, pd3_ext});
    endtask : chk_safe
    task automatic t_rst_pin;
        cyc(1);
        chk({pd3_pin_oe_n_out, pd3_pin_out, test_mode_sel_out}, 3'b011);
        pd4_ext = 1'b0;
        cyc(3);
        chk_safe();
        pd4_ext = 1'b1;
        cyc(RC + 4);
        chk(int_rst_out, 1'b0);
        pd4_gpio_sel_in = 1'b1;
        cyc(1);
        pd4_ext = 1'b0;
        cyc(4);
        chk({int_rst_out, port_d_bit4_io_out}, 2'b00);
        pd4_ext = 1'b1;
        pd4_gpio_dir_in = 1'b1;
        cyc(1);
        chk({pd4_pin_oe_n_out, pd4_pin_out}, 2'b00);
        {other_reset_in, pd3_gpio_sel_in, pd4_gpio_sel_in} = 3'b100;
        cyc(2);
        chk_safe();
        other_reset_in = 1'b0;
        cyc(RC + 4);
        pd3_ext = 1'b1;
        cyc(1);
        chk({int_rst_out, test_mode_sel_out}, 2'b01);
        cyc(1);
        chk(port_d_bit3_io_out, 1'b1);
    endtask : t_rst_pin
    task automatic t_gpio;
        for (int k = 0; k < 2; k++) begin
            pc_gpio_dir_in = (k == 0) ? 10'h155 : 10'h2AA;
            {pa_gpio_dir_in, pb_gpio_dir_in} = pc_gpio_dir_in[5:0];
            {pa_ext, pb_ext, pc_ext} = 16'hA5C3;
            {pa_gpio_dout_in, pb_gpio_dout_in, pc_gpio_dout_in} = 16'h3C96;
            cyc(3);
            chk(pc_pin_oe_n_out, pc_gpio_dir_in ^ 10'h3FF);
            chk({pa_pin_oe_n_out, pb_pin_oe_n_out},
                pc_gpio_dir_in[5:0] ^ 6'h3F);
            chk({pa_pin_out, pb_pin_out},
                {pa_gpio_dout_in, pb_gpio_dout_in});
            chk(pc_gpio_din_out, (pc_gpio_dir_in & pc_gpio_dout_in)
                | (~pc_gpio_dir_in & pc_ext));
            chk({pa_gpio_din_out, pb_gpio_din_out}, ({pa_gpio_dir_in,
                pb_gpio_dir_in} & {pa_gpio_dout_in, pb_gpio_dout_in})
                | (~{pa_gpio_dir_in, pb_gpio_dir_in} & {pa_ext, pb_ext}));
        end
    endtask : t_gpio
    task automatic t_analog;
        for (int r = 0; r < 4; r++) begin
            pa_analog_sel_in = 2'(r);
            pb_analog_sel_in = 4'h0C | 4'(r);
            conv_b_ref_mode_in = 2'(r);
            cyc(1);
            chk({conv_a_chan_en_out, comp_a_in_en_out}, {2'(r), 2'(r)});
            chk(comp_b_in_en_out, pb_analog_sel_in);
            chk({conv_b_high_reference_out, conv_b_low_reference_out},
                {conv_b_ref_mode_in[0], conv_b_ref_mode_in[1]});
            chk(conv_b_chan_en_out, {!conv_b_ref_mode_in[1],
                !conv_b_ref_mode_in[0], 2'(r)});
        end
        {pa_analog_sel_in, pb_analog_sel_in} = 6'h00;
    endtask : t_analog
    task automatic t_pc_alt;
        fn(2, SPM_FN_ALT4);
        for (int s = 0; s < 4; s++) begin
            clock_out_source_select_in = 2'(s);
            cyc(1);
            chk({pc_pin_oe_n_out[2], pc_pin_out[2]},
                {1'b0, clock_sources_in[s]});
        end
        {timer_a_oe_in, serial0_single_wire_in} = 3'b111;
        for (int m = 0; m < 4; m++) begin
            fn(2, (m < 2) ? SPM_FN_ALT1 : SPM_FN_GPIO);
            fn(7, (m < 2) ? SPM_FN_GPIO : SPM_FN_ALT2);
            fn(3, (m < 2) ? SPM_FN_ALT1 : SPM_FN_ALT2);
            fn(4, (m < 2) ? SPM_FN_ALT1 : SPM_FN_ALT2);
            cyc(1);
            chk(pc_pin_out[(m < 2) ? 2 : 7], serial0_transmit_in);
            chk(pc_pin_out[4:3], (m < 2) ? timer_a_dout_in
                : {comp_b_output_in, comp_a_output_in});
        end
        pc_fn_sel_in = 30'h0000_0000;
        pc_gpio_dir_in = 10'h000;
        fn(2, SPM_FN_ALT3);
        fn(3, SPM_FN_ALT3);
        fn(5, SPM_FN_ALT2);
        fn(6, SPM_FN_ALT2);
        fn(9, SPM_FN_ALT2);
        for (int v = 0; v < 2; v++) begin
            pc_ext = (v == 0) ? 10'h24C : 10'h030;
            cyc(3);
            chk(crossbar_in_out, {pc_ext[5], pc_ext[9], pc_ext[6],
                pc_ext[2]});
            chk(serial0_receive_out, pc_ext[3]);
            chk(timer_a_din_out, pc_ext[4:3]);
        end
        pc_fn_sel_in = 30'h0000_0000;
    endtask : t_pc_alt
    task automatic t_spi;
        fn(7, SPM_FN_ALT1);
        fn(8, SPM_FN_ALT1);
        fn(9, SPM_FN_ALT1);
        {spi_master_in, pc_ext} = 11'h080;
        cyc(3);
        chk({spi_slave_sel_n_out, pc_pin_oe_n_out[9:8]}, 3'b111);
        pc_ext = 10'h200;
        cyc(3);
        chk({spi_slave_sel_n_out, pc_pin_oe_n_out[9:8], spi_sclk_out},
            4'b0101);
        chk(pc_pin_out[8], spi_miso_in);
        {spi_master_in, pc_ext} = 11'h500;
        cyc(3);
        chk({pc_pin_oe_n_out[9:8], spi_miso_out}, 3'b011);
        chk(pc_pin_out[9], spi_sclk_in);
        spi_ss_drive_in = 1'b1;
        cyc(1);
        chk({pc_pin_oe_n_out[7], pc_pin_out[7]}, 2'b00);
    endtask : t_spi
    task automatic final_report;
        $display("Compares %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // Whole run is under a hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_sys_in) begin
        tmo++;
        if (tmo == 20000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        {num_errors, cmp_count, tmo} = '0;
        {rst_in, other_reset_in, pd3_ext, pd4_ext} = 4'h9;
        {pd3_gpio_sel_in, pd3_gpio_dout_in, pd3_gpio_dir_in} = 3'h7;
        {pd4_gpio_sel_in, pd4_gpio_dout_in, pd4_gpio_dir_in} = 3'h0;
        {pa_ext, pa_analog_sel_in, pa_gpio_dout_in, pa_gpio_dir_in} = 8'h00;
        {pb_ext, pb_analog_sel_in, pb_gpio_dout_in, pb_gpio_dir_in} = 16'h0000;
        {pc_ext, pc_gpio_dout_in, pc_gpio_dir_in} = 30'h0000_0000;
        pc_fn_sel_in = 30'h0000_0001;
        {conv_b_ref_mode_in, clock_out_source_select_in} = 4'h0;
        {timer_a_oe_in, serial0_single_wire_in} = 3'h0;
        {spi_master_in, spi_ss_drive_in} = 2'h0;
        cyc(12);
        chk_safe();
        rst_in = 1'b0;
        cyc(RC - 1);
        chk(int_rst_out, 1'b1);
        cyc(2);
        chk(int_rst_out, 1'b0);
        pc_fn_sel_in = 30'h0000_0000;
        t_rst_pin();
        t_gpio();
        t_analog();
        t_pc_alt();
        t_spi();
        final_report();
    end
endmodule : spm_pin_mux_tb
`default_nettype wire
